// File: rtl/pwr_seq_regs.svh
// register offsets, field positions, reset values and timing counts of the power sequencer
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH

// register indices; the byte address is four times the index
`define IDX_POWER_CONTROL 8'h87
`define IDX_INT_ENABLE    8'ha8
`define IDX_IO_CONTROL    8'hf8
`define IDX_EVT_STATUS    8'h10
`define IDX_EVT_MASK      8'h11
`define IDX_MODE_STATUS   8'h12

// power control fields
`define PC_BAUD_DOUBLE 7
`define PC_HARD_ARM    6
`define PC_RESUME_SEL  5
`define PC_GFLAG1      3
`define PC_GFLAG0      2
`define PC_SOFT_REQ    1
`define PC_IDLE_REQ    0
`define PC_WR_MASK     8'hef

// io control and interrupt enable fields
`define IO_FLOAT_SEL  0
`define IE_GLOBAL     7

// event bits
`define EV_HARD_ENTRY 0
`define EV_IRQ_WAKE   1
`define EV_RESET_WAKE 2
`define EV_WIDTH      3

// wake sources: all six in idle, external and timer 0/1 in soft sleep
`define SRC_IDLE 6'h3f
`define SRC_SOFT 6'h0f

`define REG_RESET 8'h00

// timing
`define CLK_PERIOD_NS 5
`define RESET_MIN_NS  1000
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/pwr_seq_pkg.sv
// types shared by the power sequencer
package pwr_seq_pkg;
   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_IDLE = 2'b01,
      ST_SOFT = 2'b11,
      ST_HARD = 2'b10
   } pd_state_t;
endpackage : pwr_seq_pkg

// File: rtl/sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,   // system clock
   input  wire logic         i_rstn,  // async reset, active low
   input  wire logic [W-1:0] i_async, // pin levels
   input  wire logic [W-1:0] i_init,  // unused-at-reset level, constant
   output logic      [W-1:0] o_sync   // synchronised levels
);
   logic [W-1:0] meta_reg;

   initial begin
      if (W < 1) $error("sync2: width must be at least 1");
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_reg <= '0;
         o_sync   <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end

   logic unused_init;
   assign unused_init = ^i_init;
endmodule : sync2
`default_nettype wire

// File: rtl/reset_pin_filter.sv
// qualifies the reset pin: one pulse once it has been high for a least width
`timescale 1ns/10ps
`default_nettype none
module reset_pin_filter #(
   parameter int MIN_CYC = 200
) (
   input  wire logic i_clk,   // system clock
   input  wire logic i_rstn,  // async reset, active low
   input  wire logic i_level, // synchronised reset pin
   output logic      o_hit    // one-cycle pulse when qualified
);
   localparam int CW = $clog2(MIN_CYC + 1);
   logic [CW-1:0] cnt_reg;

   initial begin
      if (MIN_CYC < 1) $error("reset_pin_filter: MIN_CYC must be at least 1");
   end

   // a short glitch restarts the count, so noise cannot reset the core
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_reg <= '0;
         o_hit   <= 1'b0;
      end else begin
         o_hit <= 1'b0;
         if (!i_level) begin
            cnt_reg <= '0;
         end else if (cnt_reg != CW'(MIN_CYC)) begin
            cnt_reg <= cnt_reg + CW'(1);
            o_hit   <= (cnt_reg == CW'(MIN_CYC - 1));
         end
      end
   end
endmodule : reset_pin_filter
`default_nettype wire

// File: rtl/power_down_entry_and_wake.sv
// power-down entry, pin control and wake sequencer of the core
`timescale 1ns/10ps
`default_nettype none
`include "pwr_seq_regs.svh"
module power_down_entry_and_wake #(
   parameter int RESET_MIN_CYC = `RESET_MIN_CYC
) (
   input  wire logic        i_clk,          // 200 MHz system clock
   input  wire logic        i_rstn,         // async reset, active low
   input  wire logic        i_wb_cyc,       // wishbone cycle
   input  wire logic        i_wb_stb,       // wishbone strobe
   input  wire logic        i_wb_we,        // wishbone write
   input  wire logic [9:0]  i_wb_adr,       // wishbone byte address
   input  wire logic [3:0]  i_wb_sel,       // wishbone byte selects
   input  wire logic [31:0] i_wb_dat,       // wishbone write data
   output logic      [31:0] o_wb_dat,       // wishbone read data
   output logic             o_wb_ack,       // wishbone acknowledge
   input  wire logic        i_power_fail_in,// power-fail detect pin
   input  wire logic        i_reset_pin,    // reset pin, active high
   input  wire logic        i_ext_irq0_n,   // external interrupt 0 pin
   input  wire logic        i_ext_irq1_n,   // external interrupt 1 pin
   input  wire logic        i_ext_prog,     // external program mode pin
   input  wire logic [5:0]  i_int_flags,    // interrupt flags, ie bit order
   output logic             o_irq,          // event interrupt, level
   output logic             o_cpu_clk_en,   // cpu clock enable
   output logic             o_osc_en,       // crystal oscillator enable
   output logic             o_cpu_reset,    // cpu reset pulse, restart at 0
   output logic             o_wake_vector,  // wake pulse: take vector
   output logic             o_wake_resume,  // wake pulse: resume in line
   output logic [1:0]       o_ext_flag_set, // set external flag 0/1 while pin low in sleep
   output logic             o_timer_ext_clk,// timers 0/1 on external clocks
   output logic             o_strobe_low,   // force fetch and latch strobes low
   output logic [31:0]      o_pin_drive_en, // port drive enables, p3:p0
   output pwr_seq_pkg::pd_state_t o_mode    // current mode
);
   import pwr_seq_pkg::*;

   initial begin
      if (RESET_MIN_CYC < 1) $error("RESET_MIN_CYC must be at least 1");
   end

   // pin synchronisers
   logic [4:0] pins_s;
   sync2 #(.W(5)) u_sync (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_async({i_ext_prog, i_ext_irq1_n, i_ext_irq0_n, i_reset_pin, i_power_fail_in}),
      .i_init (5'h00),
      .o_sync (pins_s)
   );
   logic pf_s, rst_s, x0_low, x1_low, ext_prog_s;
   assign pf_s       = pins_s[0];
   assign rst_s      = pins_s[1];
   assign x0_low     = ~pins_s[2];
   assign x1_low     = ~pins_s[3];
   assign ext_prog_s = pins_s[4];

   logic reset_hit;
   reset_pin_filter #(.MIN_CYC(RESET_MIN_CYC)) u_rst (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_level(rst_s),
      .o_hit  (reset_hit)
   );

   // registers
   logic [7:0] power_control_reg;
   logic [7:0] interrupt_enable_mask_reg;
   logic [7:0] io_control_reg;
   logic [`EV_WIDTH-1:0] evt_status_reg;
   logic [`EV_WIDTH-1:0] evt_mask_reg;
   pd_state_t  state_reg;
   pd_state_t  state_next;
   logic       pf_d_reg;

   // bus decode
   logic       req, wr;
   logic [7:0] idx;
   assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wr  = req & i_wb_we & i_wb_sel[0];
   assign idx = i_wb_adr[9:2];

   logic hard_arm, resume_sel, pin_float_sel, pf_fall;
   assign hard_arm      = power_control_reg[`PC_HARD_ARM];
   assign resume_sel    = power_control_reg[`PC_RESUME_SEL];
   assign pin_float_sel = io_control_reg[`IO_FLOAT_SEL];
   assign pf_fall       = pf_d_reg & ~pf_s;

   // wake evaluation; in sleep a low external pin counts as its flag
   logic [5:0] flags, src, en, hit;
   logic       wake_vec, wake_res, hard_go;
   always_comb begin
      flags = i_int_flags;
      if (state_reg != ST_RUN) begin
         flags[0] = flags[0] | x0_low;
         flags[2] = flags[2] | x1_low;
      end
      unique case (state_reg)
         ST_IDLE: src = `SRC_IDLE;
         ST_SOFT: src = `SRC_SOFT;
         ST_RUN,
         ST_HARD: src = 6'h00;
      endcase
      en       = interrupt_enable_mask_reg[`IE_GLOBAL] ? interrupt_enable_mask_reg[5:0] : 6'h00;
      hit      = flags & src;
      wake_vec = ~resume_sel & |(hit & en);
      wake_res = resume_sel & |hit;
      hard_go  = hard_arm & pf_fall & (state_reg != ST_HARD);
   end

   // mode sequencing
   always_comb begin
      state_next = state_reg;
      if (reset_hit) begin
         state_next = ST_RUN;
      end else if (hard_go) begin
         state_next = ST_HARD;
      end else begin
         unique case (state_reg)
            ST_RUN: begin
               if (power_control_reg[`PC_SOFT_REQ]) state_next = ST_SOFT;
               else if (power_control_reg[`PC_IDLE_REQ]) state_next = ST_IDLE;
            end
            ST_IDLE,
            ST_SOFT: begin
               if (wake_vec | wake_res) state_next = ST_RUN;
            end
            ST_HARD: state_next = ST_HARD;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= ST_RUN;
         pf_d_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         pf_d_reg  <= pf_s;
      end
   end

   // power control: sleep requests are dropped by hardware on every wake
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         power_control_reg <= `REG_RESET;
      end else if (reset_hit) begin
         power_control_reg <= `REG_RESET;
      end else if (state_reg != ST_RUN && state_next == ST_RUN) begin
         power_control_reg[`PC_SOFT_REQ] <= 1'b0;
         power_control_reg[`PC_IDLE_REQ] <= 1'b0;
      end else if (wr && idx == `IDX_POWER_CONTROL && state_reg == ST_RUN) begin
         power_control_reg <= i_wb_dat[7:0] & `PC_WR_MASK;
      end
   end

   // cpu is stopped in sleep, so only a running core may rewrite these
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         interrupt_enable_mask_reg <= `REG_RESET;
         io_control_reg            <= `REG_RESET;
      end else if (reset_hit) begin
         interrupt_enable_mask_reg <= `REG_RESET;
         io_control_reg            <= `REG_RESET;
      end else if (wr && state_reg == ST_RUN) begin
         if (idx == `IDX_INT_ENABLE) interrupt_enable_mask_reg <= i_wb_dat[7:0];
         if (idx == `IDX_IO_CONTROL) io_control_reg <= i_wb_dat[7:0];
      end
   end

   // event status: write one to clear, a new event wins over the clear
   logic [`EV_WIDTH-1:0] ev_set;
   assign ev_set = {reset_hit & (state_reg != ST_RUN),
                    (state_reg != ST_RUN) & (state_next == ST_RUN) & ~reset_hit,
                    hard_go & ~reset_hit};
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         evt_status_reg <= '0;
         evt_mask_reg   <= '0;
      end else begin
         if (wr && idx == `IDX_EVT_STATUS) begin
            evt_status_reg <= (evt_status_reg & ~i_wb_dat[`EV_WIDTH-1:0]) | ev_set;
         end else begin
            evt_status_reg <= evt_status_reg | ev_set;
         end
         if (wr && idx == `IDX_EVT_MASK) evt_mask_reg <= i_wb_dat[`EV_WIDTH-1:0];
      end
   end

   // wishbone answer: ack one cycle after the request, unmapped reads zero
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end else begin
         o_wb_ack <= req;
         o_wb_dat <= '0;
         if (req && !i_wb_we) begin
            unique case (idx)
               `IDX_POWER_CONTROL: o_wb_dat[7:0] <= power_control_reg;
               `IDX_INT_ENABLE:    o_wb_dat[7:0] <= interrupt_enable_mask_reg;
               `IDX_IO_CONTROL:    o_wb_dat[7:0] <= io_control_reg;
               `IDX_EVT_STATUS:    o_wb_dat[`EV_WIDTH-1:0] <= evt_status_reg;
               `IDX_EVT_MASK:      o_wb_dat[`EV_WIDTH-1:0] <= evt_mask_reg;
               `IDX_MODE_STATUS:   o_wb_dat[1:0] <= state_reg;
               default:            o_wb_dat <= '0;
            endcase
         end
      end
   end

   // pin control follows the next state so pins settle with the mode
   logic [31:0] drive_next;
   always_comb begin
      drive_next = 32'hffffffff;
      if (state_next == ST_HARD) begin
         if (pin_float_sel) begin
            drive_next = 32'h00000000;
         end else begin
            drive_next        = 32'hdfffffff;
            drive_next[7:0]   = ext_prog_s ? 8'h00 : 8'hff;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_mode          <= ST_RUN;
         o_cpu_clk_en    <= 1'b1;
         o_osc_en        <= 1'b1;
         o_timer_ext_clk <= 1'b0;
         o_strobe_low    <= 1'b0;
         o_pin_drive_en  <= 32'hffffffff;
      end else begin
         o_mode          <= state_next;
         o_cpu_clk_en    <= (state_next == ST_RUN);
         o_osc_en        <= (state_next == ST_RUN) | (state_next == ST_IDLE);
         o_timer_ext_clk <= (state_next == ST_HARD) | (state_next == ST_SOFT);
         o_strobe_low    <= (state_next == ST_HARD);
         o_pin_drive_en  <= drive_next;
      end
   end

   // wake pulses; the core pushes the stopping address for the return
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_cpu_reset    <= 1'b0;
         o_wake_vector  <= 1'b0;
         o_wake_resume  <= 1'b0;
         o_ext_flag_set <= 2'h0;
         o_irq          <= 1'b0;
      end else begin
         o_cpu_reset    <= reset_hit;
         o_wake_vector  <= ~reset_hit & ~hard_go & wake_vec;
         o_wake_resume  <= ~reset_hit & ~hard_go & wake_res;
         o_ext_flag_set <= (state_reg != ST_RUN) ? {x1_low, x0_low} : 2'h0;
         o_irq          <= |((evt_status_reg | ev_set) & evt_mask_reg);
      end
   end

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   chk_hard_entry: assert property (
      hard_arm && pf_fall && state_reg != ST_HARD && !reset_hit |=> state_reg == ST_HARD)
      else $error("armed power-fail fall did not enter hard sleep");
   chk_unarmed_stay: assert property (
      !hard_arm && state_reg != ST_HARD |=> state_reg != ST_HARD)
      else $error("hard sleep entered while unarmed");
   chk_hard_no_irq: assert property (
      state_reg == ST_HARD && !reset_hit |=> state_reg == ST_HARD && !o_wake_vector)
      else $error("hard sleep left without reset pin");
   chk_hard_clocks: assert property (
      state_reg == ST_HARD && !reset_hit |=> !o_osc_en && !o_cpu_clk_en && o_timer_ext_clk)
      else $error("clocks running in hard sleep");
   chk_float_pins: assert property (
      state_reg == ST_HARD && pin_float_sel && !reset_hit |=> o_pin_drive_en == 32'h0 && o_strobe_low)
      else $error("pins driven while floating in hard sleep");
   chk_latched_pins: assert property (
      state_reg == ST_HARD && !pin_float_sel && !reset_hit
      |=> o_pin_drive_en[31:8] == 24'hdfffff && o_strobe_low)
      else $error("ports 1-3 not driven in hard sleep");
   chk_reset_wake: assert property (
      reset_hit |=> state_reg == ST_RUN && o_cpu_reset ##1 !o_cpu_reset)
      else $error("reset pin did not restart the core");
   chk_vector_wake: assert property (
      state_reg == ST_IDLE && !resume_sel && |(i_int_flags & en) && !reset_hit && !hard_go
      |=> o_wake_vector && state_reg == ST_RUN)
      else $error("enabled interrupt failed to wake idle");
   chk_disabled_stay: assert property (
      state_reg == ST_SOFT && !resume_sel && en == 6'h0 && !reset_hit && !hard_go
      |=> state_reg == ST_SOFT)
      else $error("disabled interrupts ended soft sleep");
   chk_resume_wake: assert property (
      state_reg == ST_IDLE && resume_sel && |i_int_flags && !reset_hit && !hard_go
      |=> o_wake_resume && !o_wake_vector)
      else $error("flag did not resume from idle");
   chk_soft_sources: assert property (
      state_reg == ST_SOFT && i_int_flags[3:0] == 4'h0 && !x0_low && !x1_low
      && !reset_hit && !hard_go |=> state_reg == ST_SOFT)
      else $error("soft sleep woken by a foreign source");
   chk_ext_level: assert property (
      state_reg != ST_RUN && x0_low |=> o_ext_flag_set[0])
      else $error("low external pin did not set its flag");
   chk_soft_clocks: assert property (
      state_next == ST_SOFT |=> !o_osc_en && o_timer_ext_clk)
      else $error("oscillator running in soft sleep");
   chk_irq_level: assert property (
      (evt_status_reg & evt_mask_reg) != '0 |=> o_irq)
      else $error("pending unmasked event without interrupt");
   // the answer never stretches, so a master may rely on a single ack
   chk_ack_single: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("bus acknowledge held for two cycles");

   cov_hard_cycle: cover property (state_reg == ST_HARD ##[1:300] o_cpu_reset);
   cov_float_hard: cover property (state_reg == ST_HARD && pin_float_sel);
   cov_idle_vector: cover property (state_reg == ST_IDLE ##1 o_wake_vector);
   cov_soft_resume: cover property (state_reg == ST_SOFT ##1 o_wake_resume);
endmodule : power_down_entry_and_wake
`default_nettype wire

// File: test/pwr_pin_model.sv
// power-fail detector and reset source model at the device pins
`timescale 1ns/10ps
`default_nettype none
module pwr_pin_model (
   input  wire logic  i_clk,        // system clock
   output logic       o_power_fail, // power-fail detect, high while supply good
   output logic       o_reset_pin,  // reset pin, active high
   output logic [1:0] o_irq_n       // external interrupt pins, active low
);
   initial begin
      o_power_fail = 1'b1;
      o_reset_pin  = 1'b0;
      o_irq_n      = 2'b11; // held at a defined level, never left open
   end
   // a falling level only acts once software has armed hard sleep
   task automatic supply(input logic good);
      @(posedge i_clk) o_power_fail <= good;
   endtask : supply
   task automatic hold_reset(input int n);
      @(posedge i_clk) o_reset_pin <= 1'b1;
      repeat (n) @(posedge i_clk);
      o_reset_pin <= 1'b0;
   endtask : hold_reset
   task automatic pull_irq(input int k, input logic low);
      @(posedge i_clk) o_irq_n[k] <= ~low;
   endtask : pull_irq
endmodule : pwr_pin_model
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench of the power-down entry and wake sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pwr_seq_regs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %0h got %0h", nm, (e), (g)); end end
module tb_top;
   import pwr_seq_pkg::*;
   typedef struct packed {
      logic [7:0] ie;
      logic [7:0] pc;
      pd_state_t  m;
      logic [5:0] fl;
      logic [1:0] wk;
   } wake_t;
   localparam int MIN_CYC = 4;
   localparam logic [9:0] A_PC = {`IDX_POWER_CONTROL, 2'b00};
   localparam logic [9:0] A_IE = {`IDX_INT_ENABLE, 2'b00};
   localparam logic [9:0] A_IO = {`IDX_IO_CONTROL, 2'b00};
   localparam logic [9:0] A_ST = {`IDX_EVT_STATUS, 2'b00};
   localparam logic [9:0] A_MK = {`IDX_EVT_MASK, 2'b00};
   localparam logic [9:0] A_MS = {`IDX_MODE_STATUS, 2'b00};
   localparam logic [31:0] EXP_DRV [3] = '{32'hdfffffff, 32'hdfffff00, 32'h00000000};
   localparam wake_t WAKES [7] = '{
      '{8'h81, 8'h01, ST_IDLE, 6'h10, 2'b00},
      '{8'h81, 8'h01, ST_IDLE, 6'h01, 2'b10},
      '{8'h00, 8'h21, ST_IDLE, 6'h20, 2'b01},
      '{8'h00, 8'h22, ST_SOFT, 6'h10, 2'b00},
      '{8'h00, 8'h22, ST_SOFT, 6'h08, 2'b01},
      '{8'h8f, 8'h02, ST_SOFT, 6'h02, 2'b10},
      '{8'h00, 8'h02, ST_SOFT, 6'h3f, 2'b00}
   };
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [9:0]  adr = '0;
   logic [31:0] wdat = '0;
   logic [5:0]  flags = '0;
   logic        ext_prog = 1'b0;
   logic [31:0] rdat;
   logic [31:0] drive_en;
   logic        ack, irq, clk_en, osc_en, cpu_rst, wvec, wres, tmr_ext, strb_low;
   logic        pfail, rpin;
   logic [1:0]  ext_set, irq_n, seen;
   logic [7:0]  rd;
   pd_state_t   mode;
   wake_t       w;
   int          mismatches = 0;
   int          num_checks = 0;

   always #2.5 clk = ~clk;

   pwr_pin_model pwr_pin_model_i (.i_clk(clk), .o_power_fail(pfail), .o_reset_pin(rpin),
      .o_irq_n(irq_n));
   power_down_entry_and_wake #(.RESET_MIN_CYC(MIN_CYC)) power_down_entry_and_wake_i (
      .i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_power_fail_in(pfail), .i_reset_pin(rpin), .i_ext_irq0_n(irq_n[0]),
      .i_ext_irq1_n(irq_n[1]), .i_ext_prog(ext_prog), .i_int_flags(flags), .o_irq(irq),
      .o_cpu_clk_en(clk_en), .o_osc_en(osc_en), .o_cpu_reset(cpu_rst),
      .o_wake_vector(wvec), .o_wake_resume(wres), .o_ext_flag_set(ext_set),
      .o_timer_ext_clk(tmr_ext), .o_strobe_low(strb_low), .o_pin_drive_en(drive_en),
      .o_mode(mode));

   task automatic wb(input logic wr, input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= a; wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb
   task automatic wait_mode(input pd_state_t m);
      repeat (20) begin @(negedge clk); if (mode === m) break; end
   endtask : wait_mode
   // the pulse may land while the pin is still held, so watch alongside
   task automatic pin_reset(input int n, input logic exp);
      logic hit;
      hit = 1'b0;
      fork
         pwr_pin_model_i.hold_reset(n);
         repeat (n + 10) begin @(posedge clk); hit |= cpu_rst; end
      join
      `CHK("cpu_reset", exp, hit)
   endtask : pin_reset
   task automatic conclude;
      if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude

   initial begin
      #100us;
      mismatches++;
      conclude();
   end

   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      `CHK("rst_pins", 32'hffffffff, drive_en)
      `CHK("rst_clk", 2'b11, {osc_en, clk_en})
      wb(0, A_PC, 0); `CHK("pc_rst", 8'h00, rd)
      wb(1, A_PC, 8'hfc); wb(0, A_PC, 0); `CHK("pc_rw", 8'hec, rd)
      wb(1, A_PC, 8'h00);
      wb(0, 10'h3fc, 0); `CHK("unmapped", 8'h00, rd)
      pwr_pin_model_i.supply(0);
      repeat (8) @(posedge clk);
      `CHK("unarmed", ST_RUN, mode)
      pwr_pin_model_i.supply(1);
      for (int k = 0; k < 3; k++) begin
         wb(1, A_MK, {7'h0, k != 0});
         wb(1, A_IO, {7'h0, k == 2});
         wb(1, A_PC, 8'h40);
         ext_prog <= (k == 1);
         pwr_pin_model_i.supply(0);
         wait_mode(ST_HARD);
         `CHK("hard", ST_HARD, mode)
         `CHK("osc", 2'b00, {osc_en, clk_en})
         `CHK("hard_io", 2'b11, {tmr_ext, strb_low})
         `CHK("drive", EXP_DRV[k], drive_en)
         `CHK("irq", k != 0, irq)
         wb(0, A_ST, 0); `CHK("evt_hard", 8'h01, rd)
         wb(0, A_MS, 0); `CHK("mode_reg", 8'h02, rd)
         flags <= 6'h3f;
         pwr_pin_model_i.pull_irq(k % 2, 1);
         repeat (6) @(posedge clk);
         `CHK("ext_flag", 2'b01 << (k % 2), ext_set)
         `CHK("no_irq_exit", ST_HARD, mode)
         wb(1, A_PC, 8'h00); wb(0, A_PC, 0); `CHK("pc_kept", 8'h40, rd)
         flags <= 6'h00;
         pwr_pin_model_i.pull_irq(k % 2, 0);
         pwr_pin_model_i.supply(1);
         pin_reset(MIN_CYC - 2, 1'b0);
         `CHK("short_rst", ST_HARD, mode)
         pin_reset(MIN_CYC + 2, 1'b1);
         `CHK("rst_run", ST_RUN, mode)
         wb(0, A_PC, 0); `CHK("pc_clr", 8'h00, rd)
         wb(1, A_ST, 8'h07); @(negedge clk); `CHK("irq_clr", 1'b0, irq)
      end
      for (int k = 0; k < 7; k++) begin
         w = WAKES[k];
         wb(1, A_IE, w.ie);
         wb(1, A_PC, w.pc);
         wait_mode(w.m);
         `CHK("sleep", w.m, mode)
         `CHK("sleep_clk", {1'b0, w.m == ST_IDLE}, {clk_en, osc_en})
         `CHK("sleep_tmr", w.m == ST_SOFT, tmr_ext)
         seen = 2'b00;
         @(posedge clk) flags <= w.fl;
         repeat (10) begin @(posedge clk); seen |= {wvec, wres}; end
         flags <= 6'h00;
         `CHK("wake", w.wk, seen)
         if (w.wk == 2'b00) pin_reset(MIN_CYC + 2, 1'b1);
         @(negedge clk);
         `CHK("awake", ST_RUN, mode)
         wb(0, A_PC, 0);
         `CHK("pc_after", (w.wk == 2'b00) ? 8'h00 : (w.pc & 8'hfc), rd)
      end
      conclude();
   end
endmodule : tb_top
`default_nettype wire
